// File: rtl/tws_pkg.sv
`default_nettype none
package tws_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OWN = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_RXD = 8'h0C;
  localparam logic [7:0] REG_TXD = 8'h10;

  // field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // axi4-lite responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // link states, gray along address, data, ack
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RX = 3'b010,
    ST_RACK = 3'b110,
    ST_TX = 3'b111,
    ST_TACK = 3'b101
  } tws_state_t;

  // status word, bit 0 first from the right
  typedef struct packed {
    logic clock_wait_state;
    logic end_of_slave_access;
    logic nack_seen;
    logic general_call_seen;
    logic slave_access_active;
    logic slave_dir_is_read;
    logic tx_holding_empty;
    logic rx_holding_full;
    logic transfer_complete;
  } tws_status_t;

  localparam logic [8:0] STATUS_RST = 9'h005;

endpackage
`default_nettype wire

// File: rtl/tws_transfer.sv
`timescale 1ns/1ns
`default_nettype none
module tws_transfer #(
  parameter int ADDR_W = 7
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // two-wire pins, enable low drives low
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);

  // the decoder compares a fixed seven-bit field
  if (ADDR_W != 7) begin : g_addr_w_check
    $error("only 7-bit own addresses are served");
  end

  // ****************************************
  // pin synchronisers and bus conditions
  // ****************************************
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // meta stage feeds only the second stage
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_d <= sda_s;
    end
  end

  // data moving while the clock is high marks start and stop
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // register bus
  // ****************************************
  logic enable_reg;
  logic [6:0] own_addr_reg;
  logic [7:0] tx_hold_reg, rx_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_got_reg, w_got_reg;
  logic wr_fire, rd_fire, thr_wr, rhr_rd, stat_rd;
  tws_pkg::tws_status_t status;

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = (addr == off);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_reg(addr, tws_pkg::REG_CTRL) | is_reg(addr, tws_pkg::REG_OWN) |
                is_reg(addr, tws_pkg::REG_STAT) | is_reg(addr, tws_pkg::REG_RXD) |
                is_reg(addr, tws_pkg::REG_TXD);
  endfunction

  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign thr_wr = wr_fire & w_strb_reg[0] & is_reg(aw_addr_reg, tws_pkg::REG_TXD);
  assign rhr_rd = rd_fire & is_reg(s_axi_araddr, tws_pkg::REG_RXD);
  assign stat_rd = rd_fire & is_reg(s_axi_araddr, tws_pkg::REG_STAT);

  // address and data are caught independently, in either order
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= tws_pkg::BYTE_RST;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tws_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_reg) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control, own address and transmit data; registers sit in lane 0
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= tws_pkg::CTRL_EN_RST;
      own_addr_reg <= tws_pkg::OWN_ADDR_RST;
      tx_hold_reg <= tws_pkg::BYTE_RST;
    end else if (wr_fire & w_strb_reg[0]) begin
      if (is_reg(aw_addr_reg, tws_pkg::REG_CTRL)) begin
        enable_reg <= w_data_reg[tws_pkg::CTRL_EN_BIT];
      end else if (is_reg(aw_addr_reg, tws_pkg::REG_OWN)) begin
        if (~enable_reg | status.general_call_seen) begin
          own_addr_reg <= w_data_reg[6:0];
        end
      end else if (is_reg(aw_addr_reg, tws_pkg::REG_TXD)) begin
        tx_hold_reg <= w_data_reg[7:0];
      end
    end
  end

  // read data; unmapped addresses answer slverr with zero data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tws_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? tws_pkg::RESP_OKAY : tws_pkg::RESP_SLVERR;
      if (is_reg(s_axi_araddr, tws_pkg::REG_CTRL)) begin
        s_axi_rdata <= {31'h0000_0000, enable_reg};
      end else if (is_reg(s_axi_araddr, tws_pkg::REG_OWN)) begin
        s_axi_rdata <= {25'h000_0000, own_addr_reg};
      end else if (is_reg(s_axi_araddr, tws_pkg::REG_STAT)) begin
        s_axi_rdata <= {23'h00_0000, status};
      end else if (is_reg(s_axi_araddr, tws_pkg::REG_RXD)) begin
        s_axi_rdata <= {24'h00_0000, rx_hold_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // slave transfer engine
  // ****************************************
  tws_pkg::tws_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic sda_low_reg, stretch_reg, restart_reg, tx_valid_reg;
  logic link_go, addr_done, addr_hit, gcall_hit, rx_move, tx_load;

  assign link_go = enable_reg & ~start_cond & ~stop_cond;
  assign gcall_hit = (shift_reg == tws_pkg::GCALL_BYTE);
  assign addr_hit = (shift_reg[7:1] == own_addr_reg) | gcall_hit;
  assign addr_done = link_go & ~stretch_reg & (state_reg == tws_pkg::ST_ADDR) &
                     scl_fall & (cnt_reg == tws_pkg::BITS_PER_BYTE);
  // a byte enters the holding register at byte end or once a stretch is freed
  assign rx_move = link_go & ~status.rx_holding_full & ~status.slave_dir_is_read &
                   (stretch_reg | ((state_reg == tws_pkg::ST_RX) & scl_fall &
                   (cnt_reg == tws_pkg::BITS_PER_BYTE)));
  // a byte leaves the holding register after an ack, or when a stretch is freed
  assign tx_load = link_go & tx_valid_reg & status.slave_dir_is_read &
                   (stretch_reg | (scl_fall & ((state_reg == tws_pkg::ST_AACK) |
                   (state_reg == tws_pkg::ST_TACK))));

  // one process owns every link flag so bus clears and link sets never fight
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tws_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= tws_pkg::BYTE_RST;
      rx_hold_reg <= tws_pkg::BYTE_RST;
      sda_low_reg <= 1'b0;
      stretch_reg <= 1'b0;
      restart_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      status <= tws_pkg::STATUS_RST;
    end else begin
      // software side clears first; link sets below win in the same cycle
      if (rhr_rd) begin
        status.rx_holding_full <= 1'b0;
      end
      if (stat_rd) begin
        status.general_call_seen <= 1'b0;
        status.end_of_slave_access <= 1'b0;
        status.nack_seen <= 1'b0;
      end
      if (rx_move) begin
        rx_hold_reg <= shift_reg;
        status.rx_holding_full <= 1'b1;
        sda_low_reg <= 1'b1;
        stretch_reg <= 1'b0;
        state_reg <= tws_pkg::ST_RACK;
      end
      if (tx_load) begin
        shift_reg <= tx_hold_reg;
        tx_valid_reg <= 1'b0;
        sda_low_reg <= ~tx_hold_reg[7];
        stretch_reg <= 1'b0;
        cnt_reg <= 4'h0;
        state_reg <= tws_pkg::ST_TX;
      end
      // after the load, so a byte written as the old one leaves stays pending
      if (thr_wr) begin
        tx_valid_reg <= 1'b1;
        status.tx_holding_empty <= 1'b0;
      end
      if (~enable_reg) begin
        state_reg <= tws_pkg::ST_IDLE;
        sda_low_reg <= 1'b0;
        stretch_reg <= 1'b0;
        restart_reg <= 1'b0;
        status.slave_access_active <= 1'b0;
      end else if (start_cond) begin
        // a restart leaves access open until the next address decides
        state_reg <= tws_pkg::ST_ADDR;
        cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
        stretch_reg <= 1'b0;
        if (status.slave_access_active) begin
          restart_reg <= 1'b1;
          status.end_of_slave_access <= 1'b1;
        end
      end else if (stop_cond) begin
        state_reg <= tws_pkg::ST_IDLE;
        sda_low_reg <= 1'b0;
        stretch_reg <= 1'b0;
        restart_reg <= 1'b0;
        if (status.slave_access_active) begin
          status.slave_access_active <= 1'b0;
          status.end_of_slave_access <= 1'b1;
          status.transfer_complete <= 1'b1;
        end
      end else if (~stretch_reg) begin
        case (state_reg)
          tws_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (addr_done) begin
              restart_reg <= 1'b0;
              if (addr_hit) begin
                status.slave_access_active <= 1'b1;
                status.slave_dir_is_read <= shift_reg[0];
                status.general_call_seen <= gcall_hit;
                if (~restart_reg) begin
                  status.transfer_complete <= 1'b0;
                end
                sda_low_reg <= 1'b1;
                state_reg <= tws_pkg::ST_AACK;
              end else begin
                state_reg <= tws_pkg::ST_IDLE;
                if (restart_reg) begin
                  status.slave_access_active <= 1'b0;
                  status.transfer_complete <= 1'b1;
                end
              end
            end
          end
          tws_pkg::ST_AACK, tws_pkg::ST_TACK: begin
            if (scl_rise & (state_reg == tws_pkg::ST_TACK)) begin
              // master answered the byte just sent
              if (~tx_valid_reg) begin
                status.tx_holding_empty <= 1'b1;
              end
              if (sda_s) begin
                status.nack_seen <= 1'b1;
                state_reg <= tws_pkg::ST_IDLE;
              end
            end else if (scl_fall) begin
              // a load on this fall already put the first data bit out
              if (~tx_load) begin
                sda_low_reg <= 1'b0;
              end
              cnt_reg <= 4'h0;
              if (~status.slave_dir_is_read) begin
                state_reg <= tws_pkg::ST_RX;
              end else if (~tx_valid_reg) begin
                stretch_reg <= 1'b1;
              end
            end
          end
          tws_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall & (cnt_reg == tws_pkg::BITS_PER_BYTE) &
                         status.rx_holding_full) begin
              stretch_reg <= 1'b1;
            end
          end
          tws_pkg::ST_RACK: begin
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= tws_pkg::ST_RX;
            end
          end
          tws_pkg::ST_TX: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == tws_pkg::BITS_PER_BYTE) begin
                sda_low_reg <= 1'b0;
                state_reg <= tws_pkg::ST_TACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_low_reg <= ~shift_reg[6];
              end
            end
          end
          default: begin
            state_reg <= tws_pkg::ST_IDLE;
          end
        endcase
      end
      status.clock_wait_state <= stretch_reg;
    end
  end

  // pins only ever pull low; the wire's high level comes from the pull-up
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~stretch_reg;
  assign sda_oe_n = ~sda_low_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence s_rx_blocked;
    link_go & ~stretch_reg & (state_reg == tws_pkg::ST_RX) & scl_fall &
    (cnt_reg == tws_pkg::BITS_PER_BYTE) & status.rx_holding_full & ~rhr_rd;
  endsequence

  sequence s_held_low;
    ~scl_oe_n ##1 ~scl_oe_n;
  endsequence

  a_match_sets_access: assert property (@(posedge sys_clk) disable iff (sys_rst)
    addr_done & addr_hit |=> status.slave_access_active &
    (status.slave_dir_is_read == $past(shift_reg[0])))
    else $error("matched address did not open the access");

  a_stop_ends_access: assert property (@(posedge sys_clk) disable iff (sys_rst)
    enable_reg & stop_cond & status.slave_access_active |=> ~status.slave_access_active &
    status.transfer_complete & status.end_of_slave_access)
    else $error("stop did not close the access");

  a_rx_move_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_move |=> status.rx_holding_full & (rx_hold_reg == $past(shift_reg)) & ~sda_oe_n)
    else $error("received byte not moved to holding");

  a_rx_read_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rhr_rd & ~rx_move |=> ~status.rx_holding_full)
    else $error("holding read did not clear receive flag");

  a_tx_load_moves: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_load |=> (tx_valid_reg == $past(thr_wr)) & (state_reg == tws_pkg::ST_TX) &
    (shift_reg == $past(tx_hold_reg)) & ~status.tx_holding_empty)
    else $error("transmit byte not moved to shifter");

  a_write_stretch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_rx_blocked ##1 link_go |-> s_held_low)
    else $error("clock not held while holding register full");

  a_read_stretch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_go & scl_fall & ~stretch_reg & status.slave_dir_is_read & ~tx_valid_reg &
    ~thr_wr & (state_reg == tws_pkg::ST_AACK) ##1 link_go |-> s_held_low)
    else $error("clock not held while shifter empty");

  a_wait_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(stretch_reg) |=> status.clock_wait_state ##0 $past(~scl_oe_n))
    else $error("wait-state flag does not follow stretching");

  a_nack_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_go & ~stretch_reg & (state_reg == tws_pkg::ST_TACK) & scl_rise & sda_s
    |=> status.nack_seen & (state_reg == tws_pkg::ST_IDLE))
    else $error("master nack not flagged");

  a_gcall_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    addr_done & gcall_hit |=> status.general_call_seen & ~status.slave_dir_is_read)
    else $error("general call not flagged");

  a_restart_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
    addr_done & addr_hit & restart_reg & ~status.transfer_complete
    |=> ~status.transfer_complete)
    else $error("complete flag set on re-addressed restart");

endmodule
`default_nettype wire

// File: testbench/tws_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// two-wire bus master, open drain
// ****************************************
module tws_master_model (
  // line levels
  input wire logic scl_line,
  input wire logic sda_line,
  // high lets the line float to the pull-up
  output logic scl_rel,
  output logic sda_rel,
  // a stretch outlasted the bound
  output logic stuck
);
  // idle bus, clock stands still between frames
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    stuck = 1'b0;
  end
  // release clock, wait out a stretch under a bound
  task automatic scl_up();
    int n;
    scl_rel = 1'b1;
    for (n = 0; n < 9999 && !scl_line; n++) #1;
    stuck = !scl_line;
  endtask
  // one bit: data moves while clock low, sampled after the rise
  task automatic bit_x(input logic v, output logic b);
    sda_rel = v;
    #21;
    scl_up();
    b = sda_line;
    #63;
    scl_rel = 1'b0;
    #41;
  endtask
  // start, or repeated start from a low clock
  task automatic start();
    sda_rel = 1'b1;
    #21;
    scl_up();
    #31;
    sda_rel = 1'b0;
    #32;
    scl_rel = 1'b0;
    #41;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_rel = 1'b0;
    #21;
    scl_up();
    #31;
    sda_rel = 1'b1;
    #94;
  endtask
  // msb first, ack sampled on the ninth clock
  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic b;
    for (int i = 7; i >= 0; i--) bit_x(d[i], b);
    bit_x(1'b1, ack_n);
  endtask
  // released data line, then our own ack or nack
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, b);
  endtask
endmodule
`default_nettype wire

// File: testbench/two_wire_slave_transfer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module two_wire_slave_transfer_tb;
  // ****************************************
  // clock, reset, bus and line signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [1:0] bresp, rresp, wresp;
  logic scl_rel, sda_rel, stuck;
  wire scl_line, sda_line;
  int miscompares = 0, checks = 0;
  // wired-and of both parties on pulled-up lines
  assign scl_line = scl_rel & (scl_oe_n | scl_out);
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  always #2 sys_clk = ~sys_clk;
  tws_transfer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  tws_master_model mst (.scl_line(scl_line), .sda_line(sda_line), .scl_rel(scl_rel),
    .sda_rel(sda_rel), .stuck(stuck));
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hung();
    miscompares++;
    conclude();
  endtask
  always @(posedge stuck) hung();
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // axi write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hit, w_hit, b_hit;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // handshakes judged on settled values, never in the edge's own time step
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid;
      wresp = bresp;
      @(posedge sys_clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) break;
    end
    bready <= 1'b0;
    if (n == 50) hung();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hit, r_hit;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge sys_clk);
      ar_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) break;
    end
    rready <= 1'b0;
    if (n == 50) hung();
  endtask
  // status word under a mask; direction masked while idle
  task automatic st(input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] d;
    logic [1:0] r;
    rd(tws_pkg::REG_STAT, d, r);
    cmp(d & mask, exp);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic reset_map();
    logic [31:0] d;
    logic [1:0] r;
    st(32'h005, 32'h1FF);
    rd(8'h14, d, r);
    cmp({30'h0, r}, {30'h0, tws_pkg::RESP_SLVERR});
    wr(8'h20, 32'h1);
    cmp({30'h0, wresp}, {30'h0, tws_pkg::RESP_SLVERR});
    wr(tws_pkg::REG_OWN, 32'h2A);
    wr(tws_pkg::REG_CTRL, 32'h1);
  endtask
  task automatic write_access();
    logic a;
    logic [31:0] d;
    logic [1:0] r;
    mst.start();
    mst.wr_byte(8'h54, a);
    cmp({31'h0, a}, 32'h0);
    st(32'h014, 32'h1FF);
    mst.wr_byte(8'hA5, a);
    st(32'h016, 32'h1FF);
    // second byte finds the holding register full
    fork
      mst.wr_byte(8'h3C, a);
      begin
        repeat (300) @(posedge sys_clk);
        st(32'h116, 32'h1FF);
        rd(tws_pkg::REG_RXD, d, r);
        cmp(d, 32'hA5);
      end
    join
    cmp({31'h0, a}, 32'h0);
    st(32'h016, 32'h1FF);
    mst.stop();
    st(32'h087, 32'h1F7);
    rd(tws_pkg::REG_RXD, d, r);
    cmp(d, 32'h3C);
    st(32'h005, 32'h1F7);
  endtask
  task automatic reversal();
    logic a;
    logic [7:0] b;
    logic [31:0] d;
    logic [1:0] r;
    mst.start();
    mst.wr_byte(8'h54, a);
    mst.wr_byte(8'h11, a);
    rd(tws_pkg::REG_RXD, d, r);
    cmp(d, 32'h11);
    mst.start();
    mst.wr_byte(8'h55, a);
    st(32'h19C, 32'h1FF);
    wr(tws_pkg::REG_TXD, 32'h96);
    st(32'h018, 32'h1FF);
    mst.rd_byte(1'b0, b);
    cmp({24'h0, b}, 32'h96);
    wr(tws_pkg::REG_TXD, 32'h69);
    mst.rd_byte(1'b1, b);
    cmp({24'h0, b}, 32'h69);
    st(32'h05C, 32'h1FF);
    mst.stop();
    st(32'h085, 32'h1F7);
  endtask
  task automatic general_call();
    logic a;
    wr(tws_pkg::REG_OWN, 32'h44);
    mst.start();
    mst.wr_byte(8'h88, a);
    cmp({31'h0, a}, 32'h1);
    mst.stop();
    st(32'h005, 32'h1F7);
    mst.start();
    mst.wr_byte(8'h00, a);
    cmp({31'h0, a}, 32'h0);
    mst.wr_byte(8'h5A, a);
    wr(tws_pkg::REG_OWN, 32'h33);
    st(32'h020, 32'h020);
    mst.stop();
    mst.start();
    mst.wr_byte(8'h66, a);
    cmp({31'h0, a}, 32'h0);
    mst.stop();
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    reset_map();
    write_access();
    reversal();
    general_call();
    conclude();
  end
endmodule
`default_nettype wire
